// ---- btg_burst_ctrl.sv ----
// Functional notes
// - Counted bursts start only on a trigger from the selected origin.
// - Immediate origin requested during burst acts as the external connector.
// - Internal timer is the reset origin and fires at the burst repeat rate.
// - Bus origin starts a burst on a group execute or trigger command.
// - External origin in counted mode takes the connector trigger input.
// - Any of eight backplane lines, chosen by a 3-bit index, can trigger.
// - Gated by connector: waveform while high, DC offset while low.
// - Gated by backplane line: waveform while true, DC offset while false.
// - Bus, immediate or timer origin in gated mode becomes the connector.
// - Each counted trigger emits exactly the burst count of carrier cycles.
// - Carrier runs 10 mHz to 5 MHz, 100 kHz for triangle/ramp; default 1 kHz.
// - Arbitrary carrier maximum is 5 MHz, 2.5 MHz or 200 kHz by point count.
// - Sine, square, arbitrary: minimum count is carrier in MHz rounded up.
// - A carrier above the limit is clamped to the highest allowed; a conflicting carrier write flags -221.
// - At or below 100 Hz, count over carrier must not exceed 500 seconds.
// - External and backplane triggers act on the rising edge.
// - Counted mode: sync is low while burst cycles run, high until the next burst.
// - Burst count is 1 to 50000 or infinite, default one.
//
// Chosen here: the APB interface to the registers and the placing of the registers.
module btg_burst_ctrl (
  input  wire logic        clk_i,        // Clock, 250 MHz.
  input  wire logic        rst_i,        // Synchronous reset, active high.
  input  wire logic        psel_i,       // APB select.
  input  wire logic        penable_i,    // APB enable.
  input  wire logic        pwrite_i,     // APB direction.
  input  wire logic [7:0]  paddr_i,      // APB byte address.
  input  wire logic [31:0] pwdata_i,     // APB write data.
  output logic [31:0]      prdata_o,     // APB read data.
  output logic             pready_o,     // APB ready.
  output logic             pslverr_o,    // APB error on unmapped address.
  input  wire logic        bus_trig_i,   // Group execute / trigger command pulse.
  input  wire logic        ext_trig_i,   // Connector trigger or gate pin.
  input  wire logic [7:0]  ttl_trig_i,   // Backplane trigger lines, true high.
  output logic             wave_en_o,    // High: waveform out; low: DC offset.
  output logic             cycle_o,      // Pulse at each carrier cycle end.
  output logic             sync_o,       // Sync terminal.
  output logic             irq_o         // Level interrupt.
);
  // Register state.
  logic [31:0] ctrl_q;
  logic [15:0] count_q;
  logic [31:0] rate_q;
  logic [31:0] freq_q;
  logic [15:0] arbpts_q;
  logic [15:0] err_q;
  logic [btg_pkg::BTG_EV_W-1:0] irqst_q;
  logic [btg_pkg::BTG_EV_W-1:0] irqmsk_q;

  // Synchronisers.
  logic [8:0] sync1_q;
  logic [8:0] sync2_q;
  logic [8:0] prev_q;

  // Burst engine.
  typedef enum logic [1:0] {BTG_IDLE, BTG_RUN, BTG_GATE} btg_state_t;
  btg_state_t  state_q;
  btg_state_t  state_d;
  logic [15:0] left_q;
  logic [15:0] left_d;

  // Field decode.
  logic        burst_on;
  logic        gated;
  logic [2:0]  src_req;
  logic [2:0]  ttl_idx;
  logic [1:0]  shape;
  logic        infinite;
  logic [2:0]  src_eff;
  assign burst_on = ctrl_q[btg_pkg::BTG_CTRL_ENABLE];
  assign gated    = ctrl_q[btg_pkg::BTG_CTRL_GATED];
  assign src_req  = ctrl_q[btg_pkg::BTG_CTRL_SRC_LO +: 3];
  assign ttl_idx  = ctrl_q[btg_pkg::BTG_CTRL_TTL_LO +: 3];
  assign shape    = ctrl_q[btg_pkg::BTG_CTRL_SHP_LO +: 2];
  assign infinite = ctrl_q[btg_pkg::BTG_CTRL_INF];
  assign src_eff  = (src_req == btg_pkg::BTG_SRC_IMM) ? btg_pkg::BTG_SRC_EXT :
                    (gated && src_req != btg_pkg::BTG_SRC_TTL) ? btg_pkg::BTG_SRC_EXT : src_req;

  // Highest carrier for a shape and arbitrary point count.
  function automatic logic [31:0] max_freq(input logic [1:0] shp, input logic [15:0] pts);
    if (shp == btg_pkg::BTG_SHP_TRI) begin
      max_freq = btg_pkg::BTG_FREQ_MAX_TRI;
    end else if (shp == btg_pkg::BTG_SHP_ARB && pts > btg_pkg::BTG_ARB_PTS_12K) begin
      max_freq = btg_pkg::BTG_FREQ_MAX_A16;
    end else if (shp == btg_pkg::BTG_SHP_ARB && pts > btg_pkg::BTG_ARB_PTS_8K) begin
      max_freq = btg_pkg::BTG_FREQ_MAX_A12;
    end else begin
      max_freq = btg_pkg::BTG_FREQ_MAX;
    end
  endfunction : max_freq

  // Highest carrier the present count allows for sine, square and arbitrary shapes.
  function automatic logic [31:0] count_cap(input logic [1:0] shp, input logic [15:0] cnt);
    logic [47:0] prod;
    prod = {32'h00000000, cnt} * {16'h0000, btg_pkg::BTG_FREQ_1MHZ};
    if (shp == btg_pkg::BTG_SHP_TRI || cnt >= 16'h0005) begin
      count_cap = 32'hFFFFFFFF;
    end else begin
      count_cap = prod[31:0];
    end
  endfunction : count_cap

  // Carrier write check and clamp.
  logic [31:0] wfreq;
  logic [31:0] fmax;
  logic [31:0] fcap;
  logic [31:0] flim;
  logic [47:0] span;
  logic        slow_bad;
  logic        f_bad;
  logic [31:0] f_new;
  assign wfreq    = pwdata_i;
  assign fmax     = max_freq(shape, arbpts_q);
  assign fcap     = count_cap(shape, count_q);
  assign flim     = (fcap < fmax) ? fcap : fmax;
  assign span     = {32'h00000000, count_q} * 48'h000000000064;
  assign slow_bad = (wfreq <= btg_pkg::BTG_FREQ_100HZ) &&
                    (span > btg_pkg::BTG_SEC_LIMIT_MS * {16'h0000, wfreq}) && !infinite;
  assign f_bad    = (wfreq > flim) || slow_bad;
  assign f_new    = (wfreq < btg_pkg::BTG_FREQ_MIN) ? btg_pkg::BTG_FREQ_MIN :
                    (wfreq > flim) ? flim : wfreq;

  // APB decode.
  logic       acc;
  logic       wr;
  logic       mapped;
  logic       wr_freq;
  logic       wr_cmd;
  logic       conflict;
  assign acc      = psel_i && penable_i && !pready_o;
  assign wr       = acc && pwrite_i;
  assign mapped   = (paddr_i[1:0] == 2'h0) && (paddr_i <= btg_pkg::BTG_OFS_EFFSRC);
  assign wr_freq  = wr && paddr_i == btg_pkg::BTG_OFS_FREQ;
  assign wr_cmd   = wr && paddr_i == btg_pkg::BTG_OFS_CMD && pwdata_i[0];
  assign conflict = wr_freq && f_bad;

  // Trigger selection on synchronised inputs.
  logic [8:0] pins;
  logic       sel_lvl;
  logic       sel_prev;
  logic       rate_tick;
  logic       carrier_wrap;
  logic       carrier_half;
  logic       trig;
  logic       done;
  assign pins     = {ext_trig_i, ttl_trig_i};
  assign sel_lvl  = (src_eff == btg_pkg::BTG_SRC_TTL) ? sync2_q[ttl_idx] : sync2_q[8];
  assign sel_prev = (src_eff == btg_pkg::BTG_SRC_TTL) ? prev_q[ttl_idx] : prev_q[8];
  always_comb begin
    case (src_eff)
      btg_pkg::BTG_SRC_INT: trig = rate_tick;
      btg_pkg::BTG_SRC_BUS: trig = bus_trig_i || wr_cmd;
      btg_pkg::BTG_SRC_EXT: trig = sel_lvl && !sel_prev;
      btg_pkg::BTG_SRC_TTL: trig = sel_lvl && !sel_prev;
      default:              trig = 1'b0;
    endcase
  end

  assign done = (state_q == BTG_RUN) && carrier_wrap && !infinite && (left_q == 16'h0001);

  always_comb begin
    state_d = state_q;
    left_d  = left_q;
    case (state_q)
      BTG_IDLE: begin
        if (burst_on && gated) begin
          state_d = BTG_GATE;
        end else if (burst_on && trig) begin
          state_d = BTG_RUN;
          left_d  = count_q;
        end
      end
      BTG_RUN: begin
        if (!burst_on || gated) begin
          state_d = BTG_IDLE;
        end else if (carrier_wrap && !infinite) begin
          left_d = left_q - 16'h0001;
          if (left_q == 16'h0001) begin
            state_d = BTG_IDLE;
          end
        end
      end
      BTG_GATE: begin
        if (!burst_on || !gated) begin
          state_d = BTG_IDLE;
        end
      end
      default: state_d = BTG_IDLE;
    endcase
  end

  btg_phase_acc u_rate (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (burst_on && !gated && src_eff == btg_pkg::BTG_SRC_INT),
    .freq_i (rate_q),
    .wrap_o (rate_tick),
    .half_o ()
  );

  logic carrier_run;
  assign carrier_run = (state_q == BTG_RUN) || (state_q == BTG_GATE && sel_lvl);
  btg_phase_acc u_carrier (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (carrier_run),
    .freq_i (freq_q),
    .wrap_o (carrier_wrap),
    .half_o (carrier_half)
  );

  // Events.
  logic [btg_pkg::BTG_EV_W-1:0] ev;
  logic [btg_pkg::BTG_EV_W-1:0] irq_clr;
  assign ev      = {trig && burst_on && !gated && state_q == BTG_IDLE, conflict, done};
  assign irq_clr = (wr && paddr_i == btg_pkg::BTG_OFS_IRQST) ? pwdata_i[btg_pkg::BTG_EV_W-1:0] :
                   {btg_pkg::BTG_EV_W{1'b0}};

  // Read mux.
  logic [31:0] rd;
  always_comb begin
    case (paddr_i)
      btg_pkg::BTG_OFS_CTRL:   rd = ctrl_q;
      btg_pkg::BTG_OFS_COUNT:  rd = {16'h0000, count_q};
      btg_pkg::BTG_OFS_RATE:   rd = rate_q;
      btg_pkg::BTG_OFS_FREQ:   rd = freq_q;
      btg_pkg::BTG_OFS_ARBPTS: rd = {16'h0000, arbpts_q};
      btg_pkg::BTG_OFS_STAT:   rd = {err_q, left_q};
      btg_pkg::BTG_OFS_IRQST:  rd = {29'h00000000, irqst_q};
      btg_pkg::BTG_OFS_IRQMSK: rd = {29'h00000000, irqmsk_q};
      btg_pkg::BTG_OFS_EFFSRC: rd = {28'h0000000, state_q == BTG_IDLE, src_eff};
      default:                 rd = 32'h00000000;
    endcase
  end

  // Count write: clamp to 1..50000.
  logic [15:0] wcount;
  assign wcount = (pwdata_i[31:16] != 16'h0000 || pwdata_i[15:0] > btg_pkg::BTG_COUNT_MAX) ?
                  btg_pkg::BTG_COUNT_MAX :
                  (pwdata_i[15:0] < btg_pkg::BTG_COUNT_MIN) ? btg_pkg::BTG_COUNT_MIN : pwdata_i[15:0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q   <= {29'h00000000, btg_pkg::BTG_SRC_INT} << btg_pkg::BTG_CTRL_SRC_LO;
      count_q  <= btg_pkg::BTG_COUNT_RST;
      rate_q   <= btg_pkg::BTG_RATE_RST;
      freq_q   <= btg_pkg::BTG_FREQ_RST;
      arbpts_q <= btg_pkg::BTG_ARB_PTS_RST;
      err_q    <= 16'h0000;
      irqmsk_q <= {btg_pkg::BTG_EV_W{1'b0}};
    end else if (wr) begin
      if (paddr_i == btg_pkg::BTG_OFS_CTRL)   ctrl_q   <= pwdata_i & 32'h00013773;
      if (paddr_i == btg_pkg::BTG_OFS_COUNT)  count_q  <= wcount;
      if (paddr_i == btg_pkg::BTG_OFS_RATE)   rate_q   <= (pwdata_i > btg_pkg::BTG_RATE_MAX) ? btg_pkg::BTG_RATE_MAX :
                                                          (pwdata_i < btg_pkg::BTG_FREQ_MIN) ? btg_pkg::BTG_FREQ_MIN : pwdata_i;
      if (paddr_i == btg_pkg::BTG_OFS_ARBPTS) arbpts_q <= pwdata_i[15:0];
      if (paddr_i == btg_pkg::BTG_OFS_IRQMSK) irqmsk_q <= pwdata_i[btg_pkg::BTG_EV_W-1:0];
      if (wr_freq)                            freq_q   <= f_new;
      if (conflict)                           err_q    <= btg_pkg::BTG_ERR_CONFLICT;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= 9'h000;
      sync2_q <= 9'h000;
      prev_q  <= 9'h000;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q   <= BTG_IDLE;
      left_q    <= 16'h0000;
      irqst_q   <= {btg_pkg::BTG_EV_W{1'b0}};
      prdata_o  <= 32'h00000000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      wave_en_o <= 1'b0;
      cycle_o   <= 1'b0;
      sync_o    <= 1'b1;
      irq_o     <= 1'b0;
    end else begin
      state_q   <= state_d;
      left_q    <= left_d;
      irqst_q   <= (irqst_q & ~irq_clr) | ev;
      prdata_o  <= (acc && !pwrite_i) ? rd : 32'h00000000;
      pready_o  <= acc;
      pslverr_o <= acc && !mapped;
      wave_en_o <= state_d == BTG_RUN || (state_d == BTG_GATE && sel_lvl);
      cycle_o   <= carrier_wrap;
      // Counted bursts hold sync low for the burst; gated bursts follow the carrier polarity.
      sync_o    <= (state_d == BTG_GATE) ? (carrier_run && !carrier_half) : (state_d != BTG_RUN);
      irq_o     <= |(((irqst_q & ~irq_clr) | ev) & irqmsk_q);
    end
  end
endmodule : btg_burst_ctrl

// ---- btg_pkg.sv ----
package btg_pkg;

  // Register byte offsets.
  localparam logic [7:0] BTG_OFS_CTRL   = 8'h00;
  localparam logic [7:0] BTG_OFS_COUNT  = 8'h04;
  localparam logic [7:0] BTG_OFS_RATE   = 8'h08;
  localparam logic [7:0] BTG_OFS_FREQ   = 8'h0C;
  localparam logic [7:0] BTG_OFS_ARBPTS = 8'h10;
  localparam logic [7:0] BTG_OFS_CMD    = 8'h14;
  localparam logic [7:0] BTG_OFS_STAT   = 8'h18;
  localparam logic [7:0] BTG_OFS_IRQST  = 8'h1C;
  localparam logic [7:0] BTG_OFS_IRQMSK = 8'h20;
  localparam logic [7:0] BTG_OFS_EFFSRC = 8'h24;

  // Control register field positions.
  localparam int BTG_CTRL_ENABLE = 0;
  localparam int BTG_CTRL_GATED  = 1;
  localparam int BTG_CTRL_SRC_LO = 4;
  localparam int BTG_CTRL_TTL_LO = 8;
  localparam int BTG_CTRL_SHP_LO = 12;
  localparam int BTG_CTRL_INF    = 16;

  // Trigger origin encodings.
  localparam logic [2:0] BTG_SRC_IMM = 3'h0;
  localparam logic [2:0] BTG_SRC_INT = 3'h1;
  localparam logic [2:0] BTG_SRC_BUS = 3'h2;
  localparam logic [2:0] BTG_SRC_EXT = 3'h3;
  localparam logic [2:0] BTG_SRC_TTL = 3'h4;

  // Carrier shape encodings.
  localparam logic [1:0] BTG_SHP_SINE = 2'h0;
  localparam logic [1:0] BTG_SHP_SQR  = 2'h1;
  localparam logic [1:0] BTG_SHP_TRI  = 2'h2;
  localparam logic [1:0] BTG_SHP_ARB  = 2'h3;

  // Frequencies are held in units of 10 mHz, so that 5 MHz fits in one word.
  localparam logic [31:0] BTG_FREQ_MIN     = 32'h00000001;
  localparam logic [31:0] BTG_FREQ_MAX     = 32'h1DCD6500;       // 5 MHz.
  localparam logic [31:0] BTG_FREQ_MAX_TRI = 32'h00989680;       // 100 kHz.
  localparam logic [31:0] BTG_FREQ_MAX_A12 = 32'h0EE6B280;       // 2.5 MHz.
  localparam logic [31:0] BTG_FREQ_MAX_A16 = 32'h01312D00;       // 200 kHz.
  localparam logic [31:0] BTG_FREQ_1MHZ    = 32'h05F5E100;
  localparam logic [31:0] BTG_FREQ_100HZ   = 32'h00002710;
  localparam logic [31:0] BTG_FREQ_RST     = 32'h000186A0;       // 1 kHz.
  localparam logic [31:0] BTG_RATE_RST     = 32'h00002710;       // 100 Hz.
  localparam logic [31:0] BTG_RATE_MAX     = 32'h004C4B40;       // 50 kHz.
  localparam logic [15:0] BTG_ARB_PTS_8K   = 16'h2000;
  localparam logic [15:0] BTG_ARB_PTS_12K  = 16'h2FFF;
  localparam logic [15:0] BTG_ARB_PTS_RST  = 16'h2000;

  // Burst count limits; the slow-carrier check is count * 100 <= limit * carrier.
  localparam logic [15:0] BTG_COUNT_MIN    = 16'h0001;
  localparam logic [15:0] BTG_COUNT_MAX    = 16'hC350;
  localparam logic [15:0] BTG_COUNT_RST    = 16'h0001;
  localparam logic [47:0] BTG_SEC_LIMIT_MS = 48'h0000000001F4; // 500 s.

  // Clock rate and the period phase accumulator step base.
  localparam logic [63:0] BTG_CLK_MHZ      = 64'h00000000000000FA; // 250 MHz.
  localparam logic [63:0] BTG_CLK_CENTIHZ  = 64'h00000005D21DBA00; // 250 MHz in 10 mHz units.

  // Interrupt and status bits.
  localparam int BTG_EV_DONE     = 0;
  localparam int BTG_EV_CONFLICT = 1;
  localparam int BTG_EV_TRIGGER  = 2;
  localparam int BTG_EV_W        = 3;
  localparam logic [15:0] BTG_ERR_CONFLICT = 16'hFF23; // -221 as two's complement.

endpackage : btg_pkg

// ---- btg_phase_acc.sv ----
// Phase accumulator: pulses once per period at the programmed frequency.
module btg_phase_acc (
  input  wire logic        clk_i,    // Clock.
  input  wire logic        rst_i,    // Synchronous reset.
  input  wire logic        run_i,    // Accumulate while high.
  input  wire logic [31:0] freq_i,   // Frequency in 10 mHz units.
  output logic             wrap_o,   // One-cycle pulse per period.
  output logic             half_o    // High in the second half of a period.
);
  logic [63:0] acc_q;
  logic [63:0] acc_d;
  logic [63:0] sum;

  assign sum   = acc_q + {32'h00000000, freq_i};
  assign acc_d = !run_i ? 64'h0000000000000000 :
                 (sum >= btg_pkg::BTG_CLK_CENTIHZ) ? sum - btg_pkg::BTG_CLK_CENTIHZ : sum;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_q  <= 64'h0000000000000000;
      wrap_o <= 1'b0;
      half_o <= 1'b0;
    end else begin
      acc_q  <= acc_d;
      wrap_o <= run_i && (sum >= btg_pkg::BTG_CLK_CENTIHZ);
      half_o <= run_i && (acc_d >= (btg_pkg::BTG_CLK_CENTIHZ >> 1));
    end
  end
endmodule : btg_phase_acc

// ---- btg_burst_ctrl_assertions.sv ----
module btg_burst_ctrl_assertions (
  input  wire logic        clk_i,      // Clock.
  input  wire logic        rst_i,      // Synchronous reset.
  input  wire logic        psel_i,     // APB select.
  input  wire logic        penable_i,  // APB enable.
  input  wire logic        pwrite_i,   // APB direction.
  input  wire logic [7:0]  paddr_i,    // APB address.
  input  wire logic [31:0] prdata_o,   // APB read data.
  input  wire logic        pready_o,   // APB ready.
  input  wire logic        pslverr_o,  // APB error.
  input  wire logic        wave_en_o,  // Waveform enable.
  input  wire logic        cycle_o,    // Carrier cycle pulse.
  input  wire logic        sync_o,     // Sync terminal.
  input  wire logic        irq_o       // Interrupt.
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_access;
    psel_i && penable_i && !pready_o;
  endsequence
  sequence s_bad_addr;
    s_access ##0 ((paddr_i > 8'h24) || (paddr_i[1:0] != 2'h0));
  endsequence

  property p_rdy_answer; s_access |=> pready_o; endproperty
  a_rdy_answer: assert property (p_rdy_answer) else $error("pready missing after access");
  property p_rdy_one; pready_o |=> !pready_o; endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("pready longer than one cycle");
  property p_rdy_cause; pready_o |-> $past(psel_i && penable_i); endproperty
  a_rdy_cause: assert property (p_rdy_cause) else $error("pready without access");
  property p_err_rdy; pslverr_o |-> pready_o; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
  property p_unmapped; s_bad_addr |=> pslverr_o && (prdata_o == 32'h00000000); endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_rdata_idle; !pready_o |-> prdata_o == 32'h00000000; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside ready cycle");
  property p_reset_out;
    @(posedge clk_i) disable iff (1'b0) rst_i |=> sync_o && !wave_en_o && !irq_o && !pready_o;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs wrong in reset");
  property p_cycle_one; cycle_o |=> !cycle_o; endproperty
  a_cycle_one: assert property (p_cycle_one) else $error("cycle pulse too long");
  property p_irq_fall;
    $fell(irq_o) |-> $past(psel_i && pwrite_i, 1) || $past(psel_i && pwrite_i, 2) || $past(psel_i && pwrite_i, 3);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped without a write");
endmodule : btg_burst_ctrl_assertions

// ---- btg_trig_src.sv ----
// Connector and backplane source; levels change only when the bench asks.
module btg_trig_src (
  input  wire logic       clk_i,  // Clock used to pace changes.
  output logic            ext_o,  // Connector level.
  output logic [7:0]      ttl_o   // Backplane levels.
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ext_o = 1'b0;
    ttl_o = 8'h00;
  end
  task automatic drive(input logic e, input logic [7:0] t);
    @(posedge clk_i);
    ext_o <= e;
    ttl_o <= t;
  endtask : drive
endmodule : btg_trig_src

// ---- btg_burst_ctrl_bench.sv ----
module btg_burst_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rst_i, psel_i, penable_i, pwrite_i, bus_trig_i, pready_o, pslverr_o;
  logic        ext_trig_i, wave_en_o, cycle_o, sync_o, irq_o, er;
  logic [7:0]  paddr_i, ttl_trig_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  int          err_total, checks_done;

  btg_burst_ctrl btg_burst_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .bus_trig_i(bus_trig_i), .ext_trig_i(ext_trig_i), .ttl_trig_i(ttl_trig_i),
    .wave_en_o(wave_en_o), .cycle_o(cycle_o), .sync_o(sync_o), .irq_o(irq_o));
  btg_trig_src btg_trig_src_i (.clk_i(clk_i), .ext_o(ext_trig_i), .ttl_o(ttl_trig_i));

  task automatic finish_test();
    if (err_total == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin @(posedge clk_i); n++; end while (pready_o !== 1'b1 && n < 50);
    rd = prdata_o; er = pslverr_o;
    psel_i <= 1'b0; penable_i <= 1'b0;
    if (n >= 50) chk("pready", 32'h0, 32'h1);
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rd & m, exp);
  endtask : rchk
  function automatic logic [31:0] ctl(input logic g, input logic [2:0] s, input logic [2:0] x);
    ctl = 32'h1 | (32'(g) << btg_pkg::BTG_CTRL_GATED) | (32'(s) << btg_pkg::BTG_CTRL_SRC_LO)
        | (32'(x) << btg_pkg::BTG_CTRL_TTL_LO);
  endfunction : ctl
  // Waits for a burst, then checks its length in clocks and the sync level around it.
  task automatic burst(input int dur, input int wmax);
    int n, h, c;
    n = 0; h = 0; c = 0;
    while (wave_en_o !== 1'b1 && n < wmax) begin @(posedge clk_i); n++; end
    chk("burst_start", 32'(n < wmax), 32'h1);
    while (wave_en_o === 1'b1 && h < 4 * dur) begin
      if (sync_o !== 1'b0) chk("sync_in_burst", 32'(sync_o), 32'h0);
      if (cycle_o === 1'b1) c++;
      @(posedge clk_i); h++;
    end
    if (cycle_o === 1'b1) c++;
    chk("burst_cycles", c, 32'h2);
    chk("burst_len", 32'((h >= dur - 3) && (h <= dur + 3)), 32'h1);
    repeat (3) @(posedge clk_i);
    chk("sync_after", 32'(sync_o), 32'h1);
  endtask : burst
  task automatic quiet();
    logic seen;
    seen = 1'b0;
    repeat (30) begin @(posedge clk_i); seen = seen | wave_en_o; end
    chk("no_burst", 32'(seen), 32'h0);
  endtask : quiet
  task automatic bus_pulse();
    @(posedge clk_i) bus_trig_i <= 1'b1;
    @(posedge clk_i) bus_trig_i <= 1'b0;
  endtask : bus_pulse

  task automatic t_reset();
    rchk(btg_pkg::BTG_OFS_CTRL, 32'hFFFFFFFF, 32'h10, "ctrl");
    rchk(btg_pkg::BTG_OFS_COUNT, 32'hFFFF, 32'(btg_pkg::BTG_COUNT_RST), "count");
    rchk(btg_pkg::BTG_OFS_FREQ, 32'hFFFFFFFF, btg_pkg::BTG_FREQ_RST, "freq");
    rchk(btg_pkg::BTG_OFS_RATE, 32'hFFFFFFFF, btg_pkg::BTG_RATE_RST, "rate");
    rchk(btg_pkg::BTG_OFS_EFFSRC, 32'h7, 32'(btg_pkg::BTG_SRC_INT), "eff_src");
    apb(1'b1, 8'h28, 32'h1);
    chk("unmapped_err", 32'(er), 32'h1);
    rchk(8'h28, 32'hFFFFFFFF, 32'h0, "unmapped_rd");
    chk("unmapped_rd_err", 32'(er), 32'h1);
  endtask : t_reset
  task automatic t_bus();
    apb(1'b1, btg_pkg::BTG_OFS_COUNT, 32'h2);
    apb(1'b1, btg_pkg::BTG_OFS_FREQ, 32'h0BEBC200);
    rchk(btg_pkg::BTG_OFS_FREQ, 32'hFFFFFFFF, 32'h0BEBC200, "freq_2m");
    apb(1'b1, btg_pkg::BTG_OFS_IRQMSK, 32'h1);
    apb(1'b1, btg_pkg::BTG_OFS_CTRL, ctl(1'b0, btg_pkg::BTG_SRC_BUS, 3'h0));
    bus_pulse();
    burst(250, 20);
    chk("irq_done", 32'(irq_o), 32'h1);
    rchk(btg_pkg::BTG_OFS_IRQST, 32'h5, 32'h5, "irq_status");
    apb(1'b1, btg_pkg::BTG_OFS_IRQST, 32'h7);
    repeat (3) @(posedge clk_i);
    chk("irq_clear", 32'(irq_o), 32'h0);
    apb(1'b1, btg_pkg::BTG_OFS_CMD, 32'h1);
    burst(250, 20);
    apb(1'b1, btg_pkg::BTG_OFS_IRQMSK, 32'h0);
    repeat (3) @(posedge clk_i);
    chk("irq_masked", 32'(irq_o), 32'h0);
  endtask : t_bus
  task automatic t_ext();
    apb(1'b1, btg_pkg::BTG_OFS_CTRL, ctl(1'b0, btg_pkg::BTG_SRC_EXT, 3'h0));
    bus_pulse();
    quiet();
    btg_trig_src_i.drive(1'b1, 8'h00);
    burst(250, 20);
    quiet();
    btg_trig_src_i.drive(1'b0, 8'h01);
    quiet();
    btg_trig_src_i.drive(1'b0, 8'h00);
  endtask : t_ext
  task automatic t_ttl();
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, btg_pkg::BTG_OFS_CTRL, ctl(1'b0, btg_pkg::BTG_SRC_TTL, 3'(i)));
      btg_trig_src_i.drive(1'b0, ~(8'h01 << i));
      quiet();
      btg_trig_src_i.drive(1'b0, 8'hFF);
      burst(250, 20);
      btg_trig_src_i.drive(1'b0, 8'h00);
    end
  endtask : t_ttl
  task automatic t_imm();
    apb(1'b1, btg_pkg::BTG_OFS_CTRL, ctl(1'b0, btg_pkg::BTG_SRC_IMM, 3'h0));
    rchk(btg_pkg::BTG_OFS_EFFSRC, 32'h7, 32'(btg_pkg::BTG_SRC_EXT), "eff_imm");
    btg_trig_src_i.drive(1'b1, 8'h00);
    burst(250, 20);
    btg_trig_src_i.drive(1'b0, 8'h00);
  endtask : t_imm
  task automatic t_gated();
    logic [2:0] srcs [3];
    srcs = '{btg_pkg::BTG_SRC_IMM, btg_pkg::BTG_SRC_INT, btg_pkg::BTG_SRC_BUS};
    foreach (srcs[k]) begin
      apb(1'b1, btg_pkg::BTG_OFS_CTRL, ctl(1'b1, srcs[k], 3'h0));
      rchk(btg_pkg::BTG_OFS_EFFSRC, 32'h7, 32'(btg_pkg::BTG_SRC_EXT), "eff_gated");
    end
    btg_trig_src_i.drive(1'b1, 8'h00);
    repeat (8) @(posedge clk_i);
    chk("gate_ext_hi", 32'(wave_en_o), 32'h1);
    btg_trig_src_i.drive(1'b0, 8'h00);
    repeat (8) @(posedge clk_i);
    chk("gate_ext_lo", 32'(wave_en_o), 32'h0);
    apb(1'b1, btg_pkg::BTG_OFS_CTRL, ctl(1'b1, btg_pkg::BTG_SRC_TTL, 3'h2));
    btg_trig_src_i.drive(1'b0, 8'h04);
    repeat (8) @(posedge clk_i);
    chk("gate_ttl_hi", 32'(wave_en_o), 32'h1);
    btg_trig_src_i.drive(1'b1, 8'hFB);
    repeat (8) @(posedge clk_i);
    chk("gate_ttl_lo", 32'(wave_en_o), 32'h0);
    btg_trig_src_i.drive(1'b0, 8'h00);
  endtask : t_gated
  task automatic t_int();
    apb(1'b1, btg_pkg::BTG_OFS_RATE, btg_pkg::BTG_RATE_MAX);
    apb(1'b1, btg_pkg::BTG_OFS_CTRL, ctl(1'b0, btg_pkg::BTG_SRC_INT, 3'h0));
    burst(250, 5200);
    burst(250, 5200);
  endtask : t_int
  task automatic t_freq();
    apb(1'b1, btg_pkg::BTG_OFS_CTRL, 32'h0);
    apb(1'b1, btg_pkg::BTG_OFS_IRQST, 32'h7);
    apb(1'b1, btg_pkg::BTG_OFS_IRQMSK, 32'h2);
    apb(1'b1, btg_pkg::BTG_OFS_COUNT, 32'h1);
    apb(1'b1, btg_pkg::BTG_OFS_FREQ, 32'h0BEBC200);
    rchk(btg_pkg::BTG_OFS_FREQ, 32'hFFFFFFFF, btg_pkg::BTG_FREQ_1MHZ, "freq_clamp");
    chk("irq_conflict", 32'(irq_o), 32'h1);
    rchk(btg_pkg::BTG_OFS_STAT, 32'hFFFF0000, 32'hFF230000, "err_code");
    apb(1'b1, btg_pkg::BTG_OFS_IRQST, 32'h2);
    repeat (3) @(posedge clk_i);
    chk("irq_cleared", 32'(irq_o), 32'h0);
    apb(1'b1, btg_pkg::BTG_OFS_CTRL, 32'h2000);
    apb(1'b1, btg_pkg::BTG_OFS_FREQ, btg_pkg::BTG_FREQ_1MHZ);
    rchk(btg_pkg::BTG_OFS_FREQ, 32'hFFFFFFFF, btg_pkg::BTG_FREQ_MAX_TRI, "freq_tri");
    apb(1'b1, btg_pkg::BTG_OFS_CTRL, 32'h3000);
    apb(1'b1, btg_pkg::BTG_OFS_COUNT, 32'h5);
    apb(1'b1, btg_pkg::BTG_OFS_ARBPTS, 32'h2EE0);
    apb(1'b1, btg_pkg::BTG_OFS_FREQ, 32'h17D78400);
    rchk(btg_pkg::BTG_OFS_FREQ, 32'hFFFFFFFF, btg_pkg::BTG_FREQ_MAX_A12, "freq_arb12");
    apb(1'b1, btg_pkg::BTG_OFS_ARBPTS, 32'h3E80);
    apb(1'b1, btg_pkg::BTG_OFS_FREQ, btg_pkg::BTG_FREQ_1MHZ);
    rchk(btg_pkg::BTG_OFS_FREQ, 32'hFFFFFFFF, btg_pkg::BTG_FREQ_MAX_A16, "freq_arb16");
    apb(1'b1, btg_pkg::BTG_OFS_CTRL, 32'h0);
    apb(1'b1, btg_pkg::BTG_OFS_COUNT, 32'h0);
    rchk(btg_pkg::BTG_OFS_COUNT, 32'hFFFF, 32'h1, "count_min");
    apb(1'b1, btg_pkg::BTG_OFS_COUNT, 32'hEA60);
    rchk(btg_pkg::BTG_OFS_COUNT, 32'hFFFF, 32'hC350, "count_max");
    apb(1'b1, btg_pkg::BTG_OFS_IRQST, 32'h7);
    apb(1'b1, btg_pkg::BTG_OFS_FREQ, btg_pkg::BTG_FREQ_100HZ);
    rchk(btg_pkg::BTG_OFS_IRQST, 32'h2, 32'h0, "slow_ok");
    apb(1'b1, btg_pkg::BTG_OFS_FREQ, 32'h3E8);
    rchk(btg_pkg::BTG_OFS_IRQST, 32'h2, 32'h2, "slow_conflict");
    rchk(btg_pkg::BTG_OFS_FREQ, 32'hFFFFFFFF, 32'h3E8, "slow_kept");
  endtask : t_freq

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    #300us;
    err_total++;
    finish_test();
  end
  initial begin
    err_total = 0; checks_done = 0;
    rst_i = 1'b1; psel_i = 1'b0; penable_i = 1'b0; pwrite_i = 1'b0;
    paddr_i = 8'h00; pwdata_i = 32'h0; bus_trig_i = 1'b0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_bus();
    t_ext();
    t_ttl();
    t_imm();
    t_gated();
    t_int();
    t_freq();
    finish_test();
  end
endmodule : btg_burst_ctrl_bench

bind btg_burst_ctrl btg_burst_ctrl_assertions btg_burst_ctrl_assertions_i (.clk_i(clk_i), .rst_i(rst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .wave_en_o(wave_en_o), .cycle_o(cycle_o), .sync_o(sync_o),
  .irq_o(irq_o));
